// ===== inc/rsflow_pkg.sv
// Constants shared by the return stack flow control block.
// Assumes a 32-bit APB slave port and one core clock.
package rsflow_pkg;
	// Opcodes handled here
	localparam logic [15:0] OP_DISCARD  = 16'h0006;
	localparam logic [15:0] OP_PUSH     = 16'h0005;
	localparam logic [15:0] OP_SWRESET  = 16'h00FF;
	localparam logic [14:0] OP_IRET_HI  = 15'h0008;
	localparam logic [7:0]  OP_LRET_HI  = 8'h0C;
	localparam logic [4:0]  OP_RELATIVE_SUBROUTINE_CALL_HI = 5'h1B;
	localparam int          RELATIVE_SUBROUTINE_CALL_OFS_W = 11;

	// Quarter-phase encoding
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STAT    = 8'h04;
	localparam logic [7:0] ADDR_PC      = 8'h08;
	localparam logic [7:0] ADDR_TOP     = 8'h0C;
	localparam logic [7:0] ADDR_WORK    = 8'h10;
	localparam logic [7:0] ADDR_FLAGS   = 8'h14;
	localparam logic [7:0] ADDR_BANK    = 8'h18;
	localparam logic [7:0] ADDR_WSHAD   = 8'h1C;
	localparam logic [7:0] ADDR_FSHAD   = 8'h20;
	localparam logic [7:0] ADDR_BSHAD   = 8'h24;
	localparam logic [7:0] ADDR_IRQEN   = 8'h28;
	localparam logic [7:0] ADDR_LATCH   = 8'h2C;

	// Field positions
	localparam int CTRL_EXEC_BIT = 0;
	localparam int CTRL_LOWP_BIT = 1;
	localparam int STAT_OVF_BIT  = 0;
	localparam int STAT_UNF_BIT  = 1;
	localparam int STAT_PTR_LSB  = 8;
	localparam int IRQEN_HI_BIT  = 0;
	localparam int IRQEN_LO_BIT  = 1;
	localparam int LATCH_UP_LSB  = 8;

	// Reset values
	localparam logic [1:0]  CTRL_RST   = 2'h1;
	localparam logic [20:0] PC_RST     = 21'h00_0000;
	localparam logic [7:0]  BYTE_RST   = 8'h00;

	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_EXEC,
		CYC_NOP
	} cyc_state_t;
endpackage

// ===== verilog/return_stack_flow_control.sv
// Execution of the return stack control-flow opcodes, with an APB register file.
// Assumes one clock, instruction words presented in Q1, synchronous inputs.
// How it works
// - Discard opcode pops and drops the top
// - Push opcode stacks PC plus two, no flags
// - Every push onto a stack that is not full moves old top one down
// - Relative call carries signed 11-bit word offset
// - Call pushes PC+2, jumps PC+2+2n
// - Software reset equals master clear reset except APB answer, reset request
// - Interrupt return pops top into PC in Q4
// - Interrupt return sets high or low enable
// - Fast bit restores work, flags, bank shadows
// - Literal return loads low byte into work
// - Literal return pops PC, writes work Q4
// - Returns leave PC high latches untouched
`timescale 1ns/10ps
module return_stack_flow_control #(
	parameter int STACK_DEPTH = 31,
	parameter int PC_W        = 21,
	parameter bit OVF_RESET   = 1'b0
) (
	// Clock and reset
	input  wire logic             REF_CLK_I,
	input  wire logic             RST_N_I,
	// APB slave
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [7:0]       PADDR,
	input  wire logic [31:0]      PWDATA,
	output logic      [31:0]      PRDATA,
	output logic                  PREADY,
	output logic                  PSLVERR,
	// Instruction stream
	input  wire logic [15:0]      INSN_I,
	input  wire logic             INSN_VALID_I,
	// Core state
	output logic      [1:0]       Q_PHASE_O,
	output logic                  NOP_CYCLE_O,
	output logic      [PC_W-1:0]  PC_O,
	output logic      [PC_W-1:0]  STACK_TOP_O,
	output logic      [7:0]       WORK_O,
	output logic      [7:0]       FLAGS_O,
	output logic      [3:0]       BANK_SELECT_O,
	output logic                  HIGH_IRQ_EN_O,
	output logic                  LOW_IRQ_EN_O,
	output logic                  RESET_REQ_O
);
	localparam int PTR_W = $clog2(STACK_DEPTH + 1);

	// State
	logic [1:0]            q_phase_q;
	rsflow_pkg::cyc_state_t cyc_q;
	logic [15:0]           insn_q;
	logic [PC_W-1:0]       pc_q;
	logic [PC_W-1:0]       stack_mem [STACK_DEPTH];
	logic [PTR_W-1:0]      ptr_q;
	logic [7:0]            work_q;
	logic [7:0]            flags_q;
	logic [3:0]            bank_q;
	logic [7:0]            work_sh_q;
	logic [7:0]            flags_sh_q;
	logic [3:0]            bank_sh_q;
	logic                  gie_hi_q;
	logic                  gie_lo_q;
	logic [1:0]            ctrl_q;
	logic                  ovf_q;
	logic                  unf_q;
	logic [7:0]            latch_hi_q;
	logic [4:0]            latch_up_q;
	logic                  reset_req_q;
	logic [31:0]           prdata_q;
	logic                  pready_q;
	logic                  pslverr_q;

	// Decode of the latched opcode
	wire is_discard = (insn_q == rsflow_pkg::OP_DISCARD);
	wire is_push    = (insn_q == rsflow_pkg::OP_PUSH);
	wire is_swreset = (insn_q == rsflow_pkg::OP_SWRESET);
	wire is_iret    = (insn_q[15:1] == rsflow_pkg::OP_IRET_HI);
	wire is_lret    = (insn_q[15:8] == rsflow_pkg::OP_LRET_HI);
	wire is_relative_subroutine_call   = (insn_q[15:11] == rsflow_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI);
	wire fast_bit   = insn_q[0];
	wire two_cycle  = is_relative_subroutine_call | is_iret | is_lret;
	wire exec       = (cyc_q == rsflow_pkg::CYC_EXEC);

	// Phase strobes; Q1 is ungated for the fetch, Q2 to Q4 only for the executing instruction
	wire at_q1 = (q_phase_q == rsflow_pkg::PH_Q1);
	wire at_q2 = exec & (q_phase_q == rsflow_pkg::PH_Q2);
	wire at_q3 = exec & (q_phase_q == rsflow_pkg::PH_Q3);
	wire at_q4 = exec & (q_phase_q == rsflow_pkg::PH_Q4);

	// Stack requests: pushes in Q2, discard in Q3, returns in Q4
	wire push_req = at_q2 & (is_push | is_relative_subroutine_call);
	wire pop_req  = (at_q3 & is_discard) | (at_q4 & (is_iret | is_lret));
	wire full     = (ptr_q == PTR_W'(STACK_DEPTH));
	wire empty    = (ptr_q == '0);
	wire push_ok  = push_req & ~full;
	wire pop_ok   = pop_req & ~empty;

	// Empty stack reads as zero, so an underflowing return jumps to zero
	wire [PC_W-1:0] top_val  = empty ? '0 : stack_mem[ptr_q - PTR_W'(1)];
	wire [PC_W-1:0] pc_next2 = pc_q + PC_W'(2);
	wire [PC_W-1:0] ofs_ext  = {{(PC_W-rsflow_pkg::RELATIVE_SUBROUTINE_CALL_OFS_W-1){insn_q[10]}}, insn_q[10:0], 1'b0};
	wire [PC_W-1:0] call_tgt = pc_next2 + ofs_ext;

	// Program counter source in Q4
	wire [PC_W-1:0] pc_d = (is_iret | is_lret) ? top_val :
	                       is_relative_subroutine_call ? call_tgt : pc_next2;

	// Software reset in Q2 acts like the master clear; optional reset on overflow
	wire soft_rst = (at_q2 & is_swreset) | (push_req & full & OVF_RESET);
	wire core_rst = ~RST_N_I | soft_rst;

	// APB decode
	wire        apb_acc  = PSEL & PENABLE & ~pready_q;
	wire        apb_wr   = apb_acc & PWRITE;
	wire        wr_ctrl  = apb_wr & (PADDR == rsflow_pkg::ADDR_CTRL);
	wire        wr_stat  = apb_wr & (PADDR == rsflow_pkg::ADDR_STAT);
	wire        wr_work  = apb_wr & (PADDR == rsflow_pkg::ADDR_WORK);
	wire        wr_flags = apb_wr & (PADDR == rsflow_pkg::ADDR_FLAGS);
	wire        wr_bank  = apb_wr & (PADDR == rsflow_pkg::ADDR_BANK);
	wire        wr_wsh   = apb_wr & (PADDR == rsflow_pkg::ADDR_WSHAD);
	wire        wr_fsh   = apb_wr & (PADDR == rsflow_pkg::ADDR_FSHAD);
	wire        wr_bsh   = apb_wr & (PADDR == rsflow_pkg::ADDR_BSHAD);
	wire        wr_irq   = apb_wr & (PADDR == rsflow_pkg::ADDR_IRQEN);
	wire        wr_latch = apb_wr & (PADDR == rsflow_pkg::ADDR_LATCH);
	wire [31:0] stat_rd  = {{(24-PTR_W){1'b0}}, ptr_q, 6'h00, unf_q, ovf_q};
	wire        mapped   = (PADDR[1:0] == 2'h0) && (PADDR <= rsflow_pkg::ADDR_LATCH);

	// Read multiplexer, zero above each register's width
	logic [31:0] rd_mux;
	always_comb begin
		case (PADDR)
			rsflow_pkg::ADDR_CTRL:  rd_mux = {30'h0, ctrl_q};
			rsflow_pkg::ADDR_STAT:  rd_mux = stat_rd;
			rsflow_pkg::ADDR_PC:    rd_mux = 32'(pc_q);
			rsflow_pkg::ADDR_TOP:   rd_mux = 32'(top_val);
			rsflow_pkg::ADDR_WORK:  rd_mux = {24'h0, work_q};
			rsflow_pkg::ADDR_FLAGS: rd_mux = {24'h0, flags_q};
			rsflow_pkg::ADDR_BANK:  rd_mux = {28'h0, bank_q};
			rsflow_pkg::ADDR_WSHAD: rd_mux = {24'h0, work_sh_q};
			rsflow_pkg::ADDR_FSHAD: rd_mux = {24'h0, flags_sh_q};
			rsflow_pkg::ADDR_BSHAD: rd_mux = {28'h0, bank_sh_q};
			rsflow_pkg::ADDR_IRQEN: rd_mux = {30'h0, gie_lo_q, gie_hi_q};
			rsflow_pkg::ADDR_LATCH: rd_mux = {19'h0, latch_up_q, latch_hi_q};
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	// APB answer one cycle into the access phase; never cleared by a soft reset
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= apb_acc;
			pslverr_q <= apb_acc & ~mapped;
			prdata_q  <= (apb_acc & ~PWRITE) ? rd_mux : 32'h0000_0000;
		end
	end

	// Quarter-phase counter, free running
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) q_phase_q <= rsflow_pkg::PH_Q1;
		else          q_phase_q <= q_phase_q + 2'h1;
	end

	// Instruction cycle sequencing; second cycle of long opcodes does nothing
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			cyc_q  <= rsflow_pkg::CYC_IDLE;
			insn_q <= 16'h0000;
		end else if (q_phase_q == rsflow_pkg::PH_Q4) begin
			if (exec && two_cycle) begin
				cyc_q <= rsflow_pkg::CYC_NOP;
			end else begin
				cyc_q <= rsflow_pkg::CYC_IDLE;
			end
		end else if (at_q1 && cyc_q == rsflow_pkg::CYC_IDLE && INSN_VALID_I
		             && ctrl_q[rsflow_pkg::CTRL_EXEC_BIT]) begin
			cyc_q  <= rsflow_pkg::CYC_EXEC;
			insn_q <= INSN_I;
		end
	end

	// Program counter advances in Q4 of each executed instruction
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst)   pc_q <= rsflow_pkg::PC_RST[PC_W-1:0];
		else if (at_q4) pc_q <= pc_d;
	end

	// Stack storage: a push writes above the old top, which thus moves down
	always_ff @(posedge REF_CLK_I) begin
		if (push_ok) stack_mem[ptr_q] <= pc_next2;
	end

	// Stack pointer; popped value is simply dropped for a discard
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst)     ptr_q <= '0;
		else if (push_ok) ptr_q <= ptr_q + PTR_W'(1);
		else if (pop_ok)  ptr_q <= ptr_q - PTR_W'(1);
	end

	// Sticky stack faults; a new fault wins over a write-one clear
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end else begin
			ovf_q <= (push_req & full) | (ovf_q & ~(wr_stat & PWDATA[rsflow_pkg::STAT_OVF_BIT]));
			unf_q <= (pop_req & empty) | (unf_q & ~(wr_stat & PWDATA[rsflow_pkg::STAT_UNF_BIT]));
		end
	end

	// Control register
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst)     ctrl_q <= rsflow_pkg::CTRL_RST;
		else if (wr_ctrl) ctrl_q <= PWDATA[1:0];
	end

	// Working register: literal return beats a bus write in the same cycle
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst)                          work_q <= rsflow_pkg::BYTE_RST;
		else if (at_q4 && is_lret)             work_q <= insn_q[7:0];
		else if (at_q4 && is_iret && fast_bit) work_q <= work_sh_q;
		else if (wr_work)                      work_q <= PWDATA[7:0];
	end

	// Flags and bank select; only the fast interrupt return touches them here
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			flags_q <= rsflow_pkg::BYTE_RST;
			bank_q  <= 4'h0;
		end else if (at_q4 && is_iret && fast_bit) begin
			flags_q <= flags_sh_q;
			bank_q  <= bank_sh_q;
		end else begin
			if (wr_flags) flags_q <= PWDATA[7:0];
			if (wr_bank)  bank_q  <= PWDATA[3:0];
		end
	end

	// Shadow copies, loaded by the interrupt entry logic through the bus
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			work_sh_q  <= rsflow_pkg::BYTE_RST;
			flags_sh_q <= rsflow_pkg::BYTE_RST;
			bank_sh_q  <= 4'h0;
		end else begin
			if (wr_wsh) work_sh_q  <= PWDATA[7:0];
			if (wr_fsh) flags_sh_q <= PWDATA[7:0];
			if (wr_bsh) bank_sh_q  <= PWDATA[3:0];
		end
	end

	// Global enables: interrupt return sets the level picked in control
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			gie_hi_q <= 1'b0;
			gie_lo_q <= 1'b0;
		end else begin
			gie_hi_q <= (at_q4 & is_iret & ~ctrl_q[rsflow_pkg::CTRL_LOWP_BIT]) |
			            (wr_irq ? PWDATA[rsflow_pkg::IRQEN_HI_BIT] : gie_hi_q);
			gie_lo_q <= (at_q4 & is_iret & ctrl_q[rsflow_pkg::CTRL_LOWP_BIT]) |
			            (wr_irq ? PWDATA[rsflow_pkg::IRQEN_LO_BIT] : gie_lo_q);
		end
	end

	// PC high latches: no instruction here writes them
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			latch_hi_q <= rsflow_pkg::BYTE_RST;
			latch_up_q <= 5'h00;
		end else if (wr_latch) begin
			latch_hi_q <= PWDATA[7:0];
			latch_up_q <= PWDATA[rsflow_pkg::LATCH_UP_LSB +: 5];
		end
	end

	// Reset request pulse; only the pin clears it, so it survives the soft reset
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) reset_req_q <= 1'b0;
		else          reset_req_q <= soft_rst;
	end

	// Registered outputs
	always_ff @(posedge REF_CLK_I) begin
		if (core_rst) begin
			Q_PHASE_O     <= rsflow_pkg::PH_Q1;
			NOP_CYCLE_O   <= 1'b0;
			PC_O          <= rsflow_pkg::PC_RST[PC_W-1:0];
			STACK_TOP_O   <= '0;
		end else begin
			Q_PHASE_O     <= q_phase_q + 2'h1;
			NOP_CYCLE_O   <= (cyc_q == rsflow_pkg::CYC_NOP);
			PC_O          <= at_q4 ? pc_d : pc_q;
			STACK_TOP_O   <= top_val;
		end
	end

	// Directly registered state already sits in flip-flops
	assign WORK_O        = work_q;
	assign FLAGS_O       = flags_q;
	assign BANK_SELECT_O = bank_q;
	assign HIGH_IRQ_EN_O = gie_hi_q;
	assign LOW_IRQ_EN_O  = gie_lo_q;
	assign RESET_REQ_O   = reset_req_q;
	assign PRDATA        = prdata_q;
	assign PREADY        = pready_q;
	assign PSLVERR       = pslverr_q;

endmodule // return_stack_flow_control

// ===== sim/return_stack_flow_control_assertions.sv
// Port checks for the return stack flow control block.
// Assumes binding to the design top, one clock, sync active-low reset.
`timescale 1ns/10ps
module return_stack_flow_control_assertions #(
	parameter int PC_W = 21
) (
	// Clock, reset, APB answer
	input  wire logic            REF_CLK_I,
	input  wire logic            RST_N_I,
	input  wire logic            PSEL,
	input  wire logic            PENABLE,
	input  wire logic [31:0]     PRDATA,
	input  wire logic            PREADY,
	input  wire logic            PSLVERR,
	// Core state
	input  wire logic            NOP_CYCLE_O,
	input  wire logic [PC_W-1:0] PC_O,
	input  wire logic [7:0]      WORK_O,
	input  wire logic            HIGH_IRQ_EN_O,
	input  wire logic            LOW_IRQ_EN_O,
	input  wire logic            RESET_REQ_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	// Dummy cycle: four clocks, then gone
	sequence nop_run;
		NOP_CYCLE_O[*4] ##1 !NOP_CYCLE_O;
	endsequence

	// Bus answer shape, one wait state
	apb_wait_one_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("apb answer late");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("pready held");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("pslverr without pready");
	idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
		else $error("prdata not zero when idle");

	// Program counter moves only on word steps, never in the dummy cycle
	pc_even_a: assert property (PC_O[0] == 1'b0)
		else $error("odd program counter");
	pc_gap_a: assert property ($changed(PC_O) |=> $stable(PC_O))
		else $error("pc changed twice in a row");
	nop_hold_a: assert property (NOP_CYCLE_O |-> $stable(PC_O))
		else $error("pc moved in dummy cycle");
	nop_len_a: assert property ($rose(NOP_CYCLE_O) |-> nop_run)
		else $error("dummy cycle length wrong");

	// Software reset leaves reset values behind it
	soft_reset_a: assert property (RESET_REQ_O |-> PC_O == '0 && WORK_O == 8'h00
		&& !HIGH_IRQ_EN_O && !LOW_IRQ_EN_O)
		else $error("state not cleared by soft reset");
	req_pulse_a: assert property (RESET_REQ_O |=> !RESET_REQ_O)
		else $error("reset request held");
endmodule // return_stack_flow_control_assertions

bind return_stack_flow_control return_stack_flow_control_assertions #(.PC_W(PC_W)) chk_inst (
	.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .NOP_CYCLE_O(NOP_CYCLE_O), .PC_O(PC_O), .WORK_O(WORK_O),
	.HIGH_IRQ_EN_O(HIGH_IRQ_EN_O), .LOW_IRQ_EN_O(LOW_IRQ_EN_O), .RESET_REQ_O(RESET_REQ_O));

// ===== sim/testbench.sv
// Self-checking bench for the return stack flow control block.
// Assumes package and design compiled first; default parameters.
`timescale 1ns/10ps
module testbench;
	// Stimulus, held at rest from time zero
	logic        ref_clk    = 1'b0;
	logic        rst_n      = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic [15:0] insn       = 16'h0000;
	logic        insn_valid = 1'b0;
	// Observed outputs
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        nop_cycle;
	logic        reset_req;
	logic        high_en;
	logic        low_en;
	logic [20:0] pc;
	logic [20:0] stack_top;
	logic [7:0]  work;
	logic [7:0]  flags;
	logic [3:0]  bank;
	logic [1:0]  phase;
	logic [1:0]  ph0;
	// Bench bookkeeping
	int          err_total = 0;
	int          checked   = 0;
	int          nop_cnt;
	int          req_cnt;
	logic [31:0] rd;
	logic        rd_err;

	return_stack_flow_control return_stack_flow_control_inst (
		.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.INSN_I(insn), .INSN_VALID_I(insn_valid), .Q_PHASE_O(phase), .NOP_CYCLE_O(nop_cycle),
		.PC_O(pc), .STACK_TOP_O(stack_top), .WORK_O(work), .FLAGS_O(flags), .BANK_SELECT_O(bank),
		.HIGH_IRQ_EN_O(high_en), .LOW_IRQ_EN_O(low_en), .RESET_REQ_O(reset_req));

	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;

	// Verdict, reached from the main flow or a timeout
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Case-equality compare, so unknowns never match
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_of_test();
		end
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Four clocks of valid cover exactly one Q1; then the dummy cycle drains
	task automatic exec(input logic [15:0] op);
		nop_cnt = 0;
		req_cnt = 0;
		insn <= op;
		insn_valid <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			@(posedge ref_clk);
			if (i == 3) insn_valid <= 1'b0;
			nop_cnt += int'(nop_cycle);
			req_cnt += int'(reset_req);
		end
	endtask

	task automatic t_reset;
		apb(1'b0, rsflow_pkg::ADDR_CTRL, 32'h0000_0000);
		chk("ctrl", 32'h0000_0001, rd);
		apb(1'b0, 8'h30, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {31'h0, rd_err});
		chk("unmapped data", 32'h0000_0000, rd);
		apb(1'b1, rsflow_pkg::ADDR_PC, 32'h0000_0100);
		chk("pc read only", 32'h0000_0000, {11'h0, pc});
		// Phase output must step by one each clock
		ph0 = phase;
		@(posedge ref_clk);
		chk("phase step", {30'h0, ph0 + 2'h1}, {30'h0, phase});
		$display("test reset done");
	endtask

	task automatic t_push_pop;
		apb(1'b1, rsflow_pkg::ADDR_FLAGS, 32'h0000_00A5);
		exec(rsflow_pkg::OP_PUSH);
		chk("push top", 32'h0000_0002, {11'h0, stack_top});
		chk("push cycles", 32'h0000_0000, nop_cnt);
		exec(rsflow_pkg::OP_PUSH);
		apb(1'b0, rsflow_pkg::ADDR_TOP, 32'h0000_0000);
		chk("second push", 32'h0000_0004, rd);
		exec(rsflow_pkg::OP_DISCARD);
		chk("discard top", 32'h0000_0002, {11'h0, stack_top});
		chk("pc", 32'h0000_0006, {11'h0, pc});
		chk("flags", 32'h0000_00A5, {24'h0, flags});
		$display("test push_pop done");
	endtask

	// Both ends of the signed offset range
	task automatic t_call;
		exec({rsflow_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h3FF});
		chk("call top", 32'h0000_0008, {11'h0, stack_top});
		chk("call pc", 32'h0000_0806, {11'h0, pc});
		chk("call cycles", 32'h0000_0004, nop_cnt);
		exec({rsflow_pkg::OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h400});
		chk("back top", 32'h0000_0808, {11'h0, stack_top});
		chk("back pc", 32'h0000_0008, {11'h0, pc});
		$display("test call done");
	endtask

	task automatic t_lret;
		apb(1'b1, rsflow_pkg::ADDR_LATCH, 32'h0000_1F55);
		exec({rsflow_pkg::OP_LRET_HI, 8'h3C});
		chk("lret work", 32'h0000_003C, {24'h0, work});
		chk("lret pc", 32'h0000_0808, {11'h0, pc});
		chk("lret top", 32'h0000_0008, {11'h0, stack_top});
		chk("lret flags", 32'h0000_00A5, {24'h0, flags});
		chk("lret cycles", 32'h0000_0004, nop_cnt);
		apb(1'b0, rsflow_pkg::ADDR_LATCH, 32'h0000_0000);
		chk("latches", 32'h0000_1F55, rd);
		$display("test lret done");
	endtask

	// Plain return first, then fast return on low priority
	task automatic t_iret;
		apb(1'b1, rsflow_pkg::ADDR_WSHAD, 32'h0000_0011);
		apb(1'b1, rsflow_pkg::ADDR_FSHAD, 32'h0000_0022);
		apb(1'b1, rsflow_pkg::ADDR_BSHAD, 32'h0000_0003);
		exec({rsflow_pkg::OP_IRET_HI, 1'b0});
		chk("iret pc", 32'h0000_0008, {11'h0, pc});
		chk("iret en", 32'h0000_0002, {30'h0, high_en, low_en});
		chk("iret kept", 32'h0000_3CA5, {16'h0, work, flags});
		apb(1'b1, rsflow_pkg::ADDR_CTRL, 32'h0000_0003);
		exec({rsflow_pkg::OP_IRET_HI, 1'b1});
		chk("fast pc", 32'h0000_0002, {11'h0, pc});
		chk("fast en", 32'h0000_0003, {30'h0, high_en, low_en});
		chk("fast regs", 32'h0001_1223, {12'h0, work, flags, bank});
		$display("test iret done");
	endtask

	task automatic t_swreset;
		exec(rsflow_pkg::OP_SWRESET);
		chk("reset req", 32'h0000_0001, {31'h0, req_cnt != 0});
		chk("reset pc", 32'h0000_0000, {11'h0, pc});
		chk("reset regs", 32'h0000_0000, {10'h0, flags, work, bank, high_en, low_en});
		apb(1'b0, rsflow_pkg::ADDR_CTRL, 32'h0000_0000);
		chk("reset ctrl", 32'h0000_0001, rd);
		$display("test swreset done");
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_push_pop();
		t_call();
		t_lret();
		t_iret();
		t_swreset();
		end_of_test();
	end
endmodule // testbench
